// file: hw/time_of_day_accumulator.sv
// Notes on behaviour
// R1 - time is 48 sec, 32 ns, 8 sub-ns
// R2 - nanoseconds wrap at one second
// R3 - ns wrap increments seconds; sub-ns carries up
// R4 - runs on the synthesizer clock, programmable step
// R5 - ethernet rates handled by same programmable step
// R6 - otherwise ns counts one per clock and wraps into seconds, sub-ns zero
// R7 - flexible modulus keeps sub-ns error bounded
// R8 - advances on the third channel's clock
// R9 - load fires on seconds MSB write
// R10 - load completes within two cycles
// R11 - read of arm word captures time
// R12 - read register updated within one cycle
// R13 - selected register access pushes capture queue
// R14 - load and capture triggers are selectable
// R15 - internal pulse only captures, never loads
// R16 - gpio captures only; sync loads or captures
// R17 - global timer can load or capture
// R18 - four instances, first control at CBCC
// R19 - software prefers edge triggers for precision
// R20 - sync edge pushes time into queue
// R21 - sync edge loads write register value
// R22 - global timer counts down, fires at expiry
module time_of_day_accumulator #(
    parameter int          QUEUE_DEPTH = 4,
    parameter logic [1:0]  INSTANCE    = 2'h0
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    input  wire logic        sync_pin,
    input  wire logic        gpio_pin,
    output logic             pps_out,
    output logic             queue_ready
);
    // ==========================================================
    // address decode
    // R18 instance base
    localparam logic [15:0] INST_OFS = 16'(INSTANCE) * time_of_day_pkg::INST_STRIDE;
    localparam logic [15:0] CB = time_of_day_pkg::CTRL_BASE + INST_OFS;
    localparam logic [15:0] WB = time_of_day_pkg::WRITE_BASE + INST_OFS;
    localparam logic [15:0] RB = time_of_day_pkg::READ_BASE + INST_OFS;
    localparam int QW = $clog2(QUEUE_DEPTH);

    // offset within a block of 32 bytes, or all ones when outside
    function automatic logic [7:0] block_ofs(input logic [15:0] a, input logic [15:0] base);
        logic [15:0] d;
        d = a - base;
        block_ofs = (a >= base && d < 16'h0020) ? d[7:0] : 8'hFF;
    endfunction

    logic [7:0] c_ofs;
    logic [7:0] w_ofs;
    logic [7:0] r_ofs;
    assign c_ofs = block_ofs(addr, CB);
    assign w_ofs = block_ofs(addr, WB);
    assign r_ofs = block_ofs(addr, RB);

    // ==========================================================
    // control registers
    logic [7:0]  ctrl_r;
    logic [1:0]  load_sel_r;
    logic [2:0]  cap_sel_r;
    logic [15:0] step_r;
    logic [15:0] num_r;
    logic [15:0] den_r;
    logic [15:0] trig_addr_r;
    logic        trig_en_r;
    logic [15:0] timer_load_r;
    logic        timer_start;
    assign timer_start = wr && c_ofs == time_of_day_pkg::OFS_CTRL && wdata[time_of_day_pkg::CTRL_TIMER_BIT];

    // R14 trigger selection
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_r       <= time_of_day_pkg::CTRL_RESET;
            load_sel_r   <= 2'(time_of_day_pkg::LOAD_REG);
            cap_sel_r    <= 3'(time_of_day_pkg::CAP_NONE);
            step_r       <= time_of_day_pkg::STEP_RESET;
            num_r        <= time_of_day_pkg::NUM_RESET;
            den_r        <= time_of_day_pkg::DEN_RESET;
            trig_addr_r  <= 16'h0000;
            trig_en_r    <= 1'b0;
            timer_load_r <= 16'h0000;
        end else if (wr) begin
            case (c_ofs)
                time_of_day_pkg::OFS_CTRL:          ctrl_r <= {5'h00, 1'b0, wdata[1:0]};
                time_of_day_pkg::OFS_LOAD_SEL:      load_sel_r <= wdata[1:0];
                time_of_day_pkg::OFS_CAP_SEL:       cap_sel_r <= wdata[2:0];
                time_of_day_pkg::OFS_STEP:          step_r[7:0] <= wdata;
                time_of_day_pkg::OFS_STEP + 8'h01:  step_r[15:8] <= wdata;
                time_of_day_pkg::OFS_NUM:           num_r[7:0] <= wdata;
                time_of_day_pkg::OFS_NUM + 8'h01:   num_r[15:8] <= wdata;
                time_of_day_pkg::OFS_DEN:           den_r[7:0] <= wdata;
                time_of_day_pkg::OFS_DEN + 8'h01:   den_r[15:8] <= wdata;
                time_of_day_pkg::OFS_TRIG_ADDR:     trig_addr_r[7:0] <= wdata;
                time_of_day_pkg::OFS_TRIG_ADDR + 8'h01: trig_addr_r[15:8] <= wdata;
                time_of_day_pkg::OFS_TRIG_EN:       trig_en_r <= wdata[0];
                time_of_day_pkg::OFS_TIMER:         timer_load_r[7:0] <= wdata;
                time_of_day_pkg::OFS_TIMER + 8'h01: timer_load_r[15:8] <= wdata;
                default: ;
            endcase
        end
    end

    logic run;
    logic cyc_mode;
    assign run      = ctrl_r[time_of_day_pkg::CTRL_RUN_BIT];
    assign cyc_mode = ctrl_r[time_of_day_pkg::CTRL_CYCLE_BIT];

    // ==========================================================
    // pin synchronisers and edge detect
    logic [2:0] sync_sh_r;
    logic [2:0] gpio_sh_r;
    // stage 0 feeds only stage 1; edges compare stages 1 and 2
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sync_sh_r <= 3'h0;
            gpio_sh_r <= 3'h0;
        end else begin
            sync_sh_r <= {sync_sh_r[1:0], sync_pin};
            gpio_sh_r <= {gpio_sh_r[1:0], gpio_pin};
        end
    end
    logic sync_edge;
    logic gpio_edge;
    assign sync_edge = sync_sh_r[1] && !sync_sh_r[2];
    assign gpio_edge = gpio_sh_r[1] && !gpio_sh_r[2];

    // ==========================================================
    // global countdown timer
    logic [15:0] timer_cnt_r;
    logic        timer_fire;
    assign timer_fire = timer_cnt_r == 16'h0001;
    // R22 countdown per cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            timer_cnt_r <= 16'h0000;
        end else if (timer_start) begin
            timer_cnt_r <= timer_load_r;
        end else if (timer_cnt_r != 16'h0000) begin
            timer_cnt_r <= timer_cnt_r - 16'h0001;
        end
    end

    // ==========================================================
    // write register set and load trigger
    logic [time_of_day_pkg::TIME_W-1:0] wr_time_r;
    logic load_pend_r;
    logic load_go;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wr_time_r <= '0;
        end else if (wr && w_ofs < 8'(time_of_day_pkg::TIME_BYTES)) begin
            wr_time_r[w_ofs[3:0]*8 +: 8] <= wdata;
        end
    end
    // R9 seconds MSB write arms the load
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            load_pend_r <= 1'b0;
        end else begin
            load_pend_r <= wr && w_ofs == 8'(time_of_day_pkg::SEC_MSB_IDX)
                           && load_sel_r == 2'(time_of_day_pkg::LOAD_REG);
        end
    end
    // R15 R16 R17 R21 only register write, sync edge or timer load, never pps or gpio
    always_comb begin
        case (load_sel_r)
            2'(time_of_day_pkg::LOAD_REG):   load_go = load_pend_r;
            2'(time_of_day_pkg::LOAD_SYNC):  load_go = sync_edge;
            2'(time_of_day_pkg::LOAD_TIMER): load_go = timer_fire;
            default:                         load_go = 1'b0;
        endcase
    end

    // ==========================================================
    // accumulator
    // R1 seconds, ns, sub-ns fields
    logic [time_of_day_pkg::SEC_W-1:0] sec_r;
    logic [time_of_day_pkg::NS_W-1:0]  ns_r;
    logic [time_of_day_pkg::SUB_W-1:0] sub_r;
    logic [15:0] resid_r;
    logic [time_of_day_pkg::TIME_W-1:0] time_acc;
    assign time_acc = {sec_r, ns_r, sub_r};
    logic [16:0] rsum;
    logic        extra;
    logic [15:0] resid_nxt;
    logic [16:0] units;
    logic [8:0]  sub_sum;
    logic [32:0] ns_sum;
    logic        wrap;
    // R7 flexible modulus: residue carries the fraction of a unit
    always_comb begin
        rsum      = {1'b0, resid_r} + {1'b0, num_r};
        extra     = den_r != 16'h0000 && rsum >= {1'b0, den_r};
        resid_nxt = extra ? 16'(rsum - {1'b0, den_r}) : rsum[15:0];
        units     = {1'b0, step_r} + {16'h0000, extra};
        sub_sum   = {1'b0, sub_r} + {1'b0, units[7:0]};
        // R6 cycle mode adds one nanosecond per clock
        if (cyc_mode) begin
            ns_sum = {1'b0, ns_r} + 33'h000000001;
        end else begin
            // R3 sub-ns carry into nanoseconds
            ns_sum = {1'b0, ns_r} + {24'h000000, units[16:8]} + {32'h00000000, sub_sum[8]};
        end
        wrap = ns_sum > {1'b0, time_of_day_pkg::NS_MAX};
    end

    logic pps_evt;
    assign pps_evt = run && !load_go && wrap;

    // R4 R5 R8 advances once per synthesizer clock of the third channel
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sec_r   <= '0;
            ns_r    <= '0;
            sub_r   <= '0;
            resid_r <= 16'h0000;
        end else if (load_go) begin
            // R10 R21 load takes effect at this edge
            sec_r   <= wr_time_r[87:40];
            ns_r    <= wr_time_r[39:8];
            sub_r   <= cyc_mode ? 8'h00 : wr_time_r[7:0];
            resid_r <= 16'h0000;
        end else if (run) begin
            // R2 wrap at one second
            if (wrap) begin
                ns_r  <= 32'(ns_sum - time_of_day_pkg::NS_ONE_SEC);
                // R3 seconds increment
                sec_r <= sec_r + 48'h000000000001;
            end else begin
                ns_r <= ns_sum[31:0];
            end
            sub_r   <= cyc_mode ? 8'h00 : sub_sum[7:0];
            resid_r <= cyc_mode ? 16'h0000 : resid_nxt;
        end else if (cyc_mode) begin
            sub_r <= 8'h00;
        end
    end

    // ==========================================================
    // capture into read register and queue
    logic cap_evt;
    // R15 R16 R17 capture source choice
    always_comb begin
        case (cap_sel_r)
            3'(time_of_day_pkg::CAP_PPS):   cap_evt = pps_evt;
            3'(time_of_day_pkg::CAP_SYNC):  cap_evt = sync_edge;
            3'(time_of_day_pkg::CAP_GPIO):  cap_evt = gpio_edge;
            3'(time_of_day_pkg::CAP_TIMER): cap_evt = timer_fire;
            default:                        cap_evt = 1'b0;
        endcase
    end
    logic arm_read;
    assign arm_read = rd && r_ofs == time_of_day_pkg::OFS_READ_ARM;

    logic [time_of_day_pkg::TIME_W-1:0] rd_time_r;
    // R11 R12 arm read latches the accumulator at the same edge
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_time_r <= '0;
        end else if (arm_read || cap_evt) begin
            rd_time_r <= time_acc;
        end
    end

    logic [time_of_day_pkg::TIME_W-1:0] q_mem [QUEUE_DEPTH];
    logic [QW-1:0] q_wp_r;
    logic [QW-1:0] q_rp_r;
    logic [QW:0]   q_cnt_r;
    logic          ovf_r;
    logic csr_hit;
    logic push;
    logic pop;
    logic q_full;
    // R13 any access at the chosen address captures
    assign csr_hit = trig_en_r && (rd || wr) && addr == trig_addr_r;
    assign q_full  = q_cnt_r == (QW+1)'(QUEUE_DEPTH);
    // R20 selected edges also feed the queue
    assign push    = (csr_hit || cap_evt) && !q_full;
    assign pop     = rd && c_ofs == time_of_day_pkg::OFS_QUEUE_END && q_cnt_r != '0;

    always_ff @(posedge clock) begin
        if (push) begin
            q_mem[q_wp_r] <= time_acc;
        end
    end
    // pointers wrap with the depth; depth must be a power of two
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q_wp_r  <= '0;
            q_rp_r  <= '0;
            q_cnt_r <= '0;
        end else begin
            if (push) begin
                q_wp_r <= q_wp_r + QW'(1);
            end
            if (pop) begin
                q_rp_r <= q_rp_r + QW'(1);
            end
            q_cnt_r <= q_cnt_r + (QW+1)'(push) - (QW+1)'(pop);
        end
    end
    // overflow is sticky; a new overflow wins over the clear
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ovf_r <= 1'b0;
        end else if ((csr_hit || cap_evt) && q_full) begin
            ovf_r <= 1'b1;
        end else if (wr && c_ofs == time_of_day_pkg::OFS_STATUS && wdata[time_of_day_pkg::STATUS_OVF_BIT]) begin
            ovf_r <= 1'b0;
        end
    end

    // ==========================================================
    // read data and outputs
    logic [7:0] rdata_nxt;
    logic [7:0] qi;
    logic [7:0] ri;
    always_comb begin
        qi = c_ofs - time_of_day_pkg::OFS_QUEUE;
        ri = r_ofs - time_of_day_pkg::OFS_READ_TIME;
        rdata_nxt = 8'h00;
        if (c_ofs >= time_of_day_pkg::OFS_QUEUE && c_ofs <= time_of_day_pkg::OFS_QUEUE_END) begin
            rdata_nxt = q_mem[q_rp_r][qi[3:0]*8 +: 8];
        end else if (r_ofs >= time_of_day_pkg::OFS_READ_TIME
                     && ri < 8'(time_of_day_pkg::TIME_BYTES)) begin
            rdata_nxt = rd_time_r[ri[3:0]*8 +: 8];
        end else if (w_ofs < 8'(time_of_day_pkg::TIME_BYTES)) begin
            rdata_nxt = wr_time_r[w_ofs[3:0]*8 +: 8];
        end else begin
            case (c_ofs)
                time_of_day_pkg::OFS_CTRL:              rdata_nxt = ctrl_r;
                time_of_day_pkg::OFS_LOAD_SEL:          rdata_nxt = {6'h00, load_sel_r};
                time_of_day_pkg::OFS_CAP_SEL:           rdata_nxt = {5'h00, cap_sel_r};
                time_of_day_pkg::OFS_STEP:              rdata_nxt = step_r[7:0];
                time_of_day_pkg::OFS_STEP + 8'h01:      rdata_nxt = step_r[15:8];
                time_of_day_pkg::OFS_NUM:               rdata_nxt = num_r[7:0];
                time_of_day_pkg::OFS_NUM + 8'h01:       rdata_nxt = num_r[15:8];
                time_of_day_pkg::OFS_DEN:               rdata_nxt = den_r[7:0];
                time_of_day_pkg::OFS_DEN + 8'h01:       rdata_nxt = den_r[15:8];
                time_of_day_pkg::OFS_TRIG_ADDR:         rdata_nxt = trig_addr_r[7:0];
                time_of_day_pkg::OFS_TRIG_ADDR + 8'h01: rdata_nxt = trig_addr_r[15:8];
                time_of_day_pkg::OFS_TRIG_EN:           rdata_nxt = {7'h00, trig_en_r};
                time_of_day_pkg::OFS_TIMER:             rdata_nxt = timer_load_r[7:0];
                time_of_day_pkg::OFS_TIMER + 8'h01:     rdata_nxt = timer_load_r[15:8];
                time_of_day_pkg::OFS_STATUS:            rdata_nxt = {4'(q_cnt_r), 3'h0, ovf_r};
                default:                                rdata_nxt = 8'h00;
            endcase
        end
    end
    // registered answer; data only meaningful the cycle after rd
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata       <= 8'h00;
            pps_out     <= 1'b0;
            queue_ready <= 1'b0;
        end else begin
            rdata       <= rd ? rdata_nxt : 8'h00;
            pps_out     <= pps_evt;
            queue_ready <= (q_cnt_r + (QW+1)'(push) - (QW+1)'(pop)) != '0;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_ns_in_range: assert property (ns_r <= time_of_day_pkg::NS_MAX || $past(load_go)) // R2
        else $error("nanoseconds beyond one second");
    a_sec_carry: assert property (run && !load_go && wrap |=> sec_r == $past(sec_r) + 48'h1) // R3
        else $error("seconds missed wrap carry");
    a_cycle_sub: assert property (cyc_mode && $past(cyc_mode) |-> sub_r == 8'h00) // R6
        else $error("sub-ns not zero in cycle mode");
    a_resid_bound: assert property (den_r != 16'h0 && $stable(den_r) && !cyc_mode |=> resid_r < den_r || $changed(den_r)) // R7
        else $error("modulus residue out of range");
    a_msb_load: assert property (wr && w_ofs == 8'h0A && load_sel_r == 2'b00 |-> ##2 time_acc == $past(wr_time_r)) // R9
        else $error("seconds MSB write did not load");
    a_load_source: assert property (load_go |-> (load_sel_r == 2'b00 && load_pend_r) || (load_sel_r == 2'b01 && sync_edge) || (load_sel_r == 2'b10 && timer_fire)) // R15
        else $error("load from illegal source");
    a_arm_latch: assert property (arm_read |=> rd_time_r == $past(time_acc)) // R11
        else $error("arm read did not latch time");
    a_csr_push: assert property (csr_hit && !q_full && !pop |=> q_cnt_r == $past(q_cnt_r) + 1'b1) // R13
        else $error("register trigger did not push");
    a_sync_capture: assert property (cap_sel_r == 3'b010 && sync_edge |=> rd_time_r == $past(time_acc)) // R20
        else $error("sync edge did not capture");
    a_timer_expiry: assert property (timer_cnt_r == 16'h2 && !timer_start |=> timer_fire ##1 timer_cnt_r == 16'h0 || $past(timer_start)) // R22
        else $error("timer did not fire on expiry");

    c_reg_load: cover property (load_pend_r ##1 run);
    c_sec_wrap: cover property (pps_evt);
    c_queue_full: cover property (q_full && csr_hit);
    c_timer_load: cover property (timer_fire && load_sel_r == 2'b10);
endmodule

// file: inc/time_of_day_pkg.sv
package time_of_day_pkg;
    // ==========================================================
    // address map, byte wide registers
    localparam logic [15:0] CTRL_BASE     = 16'hCBCC;
    localparam logic [15:0] WRITE_BASE    = 16'hCC00;
    localparam logic [15:0] READ_BASE     = 16'hCC40;
    localparam logic [15:0] INST_STRIDE   = 16'h0100;
    // offsets inside the control block
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_LOAD_SEL  = 8'h01;
    localparam logic [7:0]  OFS_CAP_SEL   = 8'h02;
    localparam logic [7:0]  OFS_STEP      = 8'h03;
    localparam logic [7:0]  OFS_NUM       = 8'h05;
    localparam logic [7:0]  OFS_DEN       = 8'h07;
    localparam logic [7:0]  OFS_TRIG_ADDR = 8'h09;
    localparam logic [7:0]  OFS_TRIG_EN   = 8'h0B;
    localparam logic [7:0]  OFS_TIMER     = 8'h0C;
    localparam logic [7:0]  OFS_STATUS    = 8'h0E;
    localparam logic [7:0]  OFS_QUEUE     = 8'h0F;
    localparam logic [7:0]  OFS_QUEUE_END = 8'h19;
    // offsets inside the read block
    localparam logic [7:0]  OFS_READ_ARM  = 8'h00;
    localparam logic [7:0]  OFS_READ_TIME = 8'h01;
    // control register fields
    localparam int CTRL_RUN_BIT   = 0;
    localparam int CTRL_CYCLE_BIT = 1;
    localparam int CTRL_TIMER_BIT = 2;
    localparam int STATUS_OVF_BIT = 0;
    // time value layout
    localparam int TIME_BYTES  = 11;
    localparam int TIME_W      = 88;
    localparam int SUB_W       = 8;
    localparam int NS_W        = 32;
    localparam int SEC_W       = 48;
    localparam int SEC_MSB_IDX = 10;
    localparam logic [NS_W-1:0] NS_MAX = 32'h3B9AC9FF;
    localparam logic [NS_W:0]   NS_ONE_SEC = 33'h03B9ACA00;
    // reset values: 10 ns per cycle at 1/256 ns units
    localparam real CLOCK_NS = 10.0;
    localparam logic [15:0] STEP_RESET = 16'(int'(CLOCK_NS * 256.0));
    localparam logic [15:0] NUM_RESET  = 16'h0000;
    localparam logic [15:0] DEN_RESET  = 16'h0001;
    localparam logic [7:0]  CTRL_RESET = 8'h01;

    typedef enum logic [1:0] {
        LOAD_REG   = 2'b00,
        LOAD_SYNC  = 2'b01,
        LOAD_TIMER = 2'b10,
        LOAD_OFF   = 2'b11
    } load_sel_type;

    typedef enum logic [2:0] {
        CAP_NONE  = 3'b000,
        CAP_PPS   = 3'b001,
        CAP_SYNC  = 3'b010,
        CAP_GPIO  = 3'b011,
        CAP_TIMER = 3'b100
    } cap_sel_type;
endpackage

// file: testbench/host_model.sv
// ==========================================================
// host side of the byte register port
module host_model (
    input  wire logic        clock,
    output logic      [15:0] addr,
    output logic      [7:0]  wdata,
    output logic             wr,
    output logic             rd,
    input  wire logic [7:0]  rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial begin
        addr  = 16'h0000;
        wdata = 8'h00;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    // one write strobe, then an idle cycle so back-to-back calls never retoggle wr in one step
    task automatic put(input logic [15:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
        wdata <= ~d; // released data shows no stale value
        @(posedge clock);
    endtask

    // read data is taken in the cycle after the strobe only
    task automatic get(input logic [15:0] a, output logic [7:0] d);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        addr <= ~a;
        @(posedge clock);
        d = rdata;
    endtask

    task automatic put_time(input logic [87:0] v);
        for (int i = 0; i < time_of_day_pkg::TIME_BYTES; i++) begin
            put(time_of_day_pkg::WRITE_BASE + 16'(i), v[8*i +: 8]);
        end
    endtask

    // eleven consecutive bytes, lowest address is the lowest byte
    task automatic get_block(input logic [15:0] base, output logic [87:0] v);
        logic [7:0] b;
        for (int i = 0; i < time_of_day_pkg::TIME_BYTES; i++) begin
            get(base + 16'(i), b);
            v[8*i +: 8] = b;
        end
    endtask

    task automatic get_time(output logic [87:0] v);
        logic [7:0] b;
        get(time_of_day_pkg::READ_BASE, b);
        get_block(time_of_day_pkg::READ_BASE + 16'h0001, v);
    endtask
endmodule

// file: testbench/time_of_day_accumulator_bench.sv
// ==========================================================
// self-checking bench for the accumulator
module time_of_day_accumulator_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] CTRL = time_of_day_pkg::CTRL_BASE;
    logic        clock    = 1'b0;
    logic        rst_n    = 1'b0;
    logic        sync_pin = 1'b0;
    logic        gpio_pin = 1'b0;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic        pps_out;
    logic        queue_ready;
    logic [87:0] t;
    logic [87:0] u;
    logic [87:0] v;
    int          errors          = 0;
    int          samples_checked = 0;
    int          pps_seen        = 0;

    always #5 clock = ~clock;

    // count wrap pulses as they go by
    always @(posedge clock) begin
        if (pps_out === 1'b1) begin
            pps_seen++;
        end
    end

    host_model HOST (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

    time_of_day_accumulator DUT (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .sync_pin(sync_pin), .gpio_pin(gpio_pin), .pps_out(pps_out),
        .queue_ready(queue_ready));

    task automatic end_of_test;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [87:0] e, input logic [87:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic rchk(input string name, input logic [15:0] a, input logic [7:0] e);
        logic [7:0] b;
        HOST.get(a, b);
        chk(name, 88'(e), 88'(b));
    endtask

    task automatic tchk(input string name, input logic [87:0] e);
        logic [87:0] v;
        HOST.get_time(v);
        chk(name, e, v);
    endtask

    // run for exactly two accumulator steps, then freeze again
    task automatic pulse_run(input logic [7:0] mode);
        HOST.put(CTRL, mode | 8'h01);
        HOST.put(CTRL, mode);
    endtask

    // edge timed loads; sync seen after two flops
    task automatic sync_pulse;
        sync_pin <= 1'b1;
        repeat (3) @(posedge clock);
        sync_pin <= 1'b0;
        repeat (4) @(posedge clock);
    endtask

    // gpio edge also passes the two-flop synchroniser
    task automatic gpio_pulse;
        gpio_pin <= 1'b1;
        repeat (3) @(posedge clock);
        gpio_pin <= 1'b0;
        repeat (4) @(posedge clock);
    endtask

    // the whole test takes far less than this span
    initial begin
        #200000;
        errors++;
        end_of_test();
    end

    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rchk("ctrl_reset", CTRL, 8'h01);
        rchk("step_reset", CTRL + 16'h0004, 8'h0A);
        rchk("den_reset", CTRL + 16'h0007, 8'h01);
        rchk("unmapped", 16'hCBF0, 8'h00);
        HOST.put(CTRL, 8'h00);
        t = {48'h0000_1234_5678, 32'h1234_5678, 8'h9A};
        HOST.put_time(t);
        tchk("loaded", t);
        for (int i = 0; i < 10; i++) begin
            HOST.put(time_of_day_pkg::WRITE_BASE + 16'(i), 8'hFF);
        end
        tchk("no_early_load", t);
        HOST.put_time({48'h5, 32'h3B9AC9EC, 8'h00});
        pulse_run(8'h00);
        tchk("ns_wrap", {48'h6, 32'h0, 8'h00});
        chk("pps_count", 88'd1, 88'(pps_seen));
        HOST.put_time({48'h7, 32'h5, 8'h00});
        pulse_run(8'h02);
        tchk("cycle_mode", {48'h7, 32'h7, 8'h00});
        HOST.put(CTRL + 16'h0005, 8'h01);
        HOST.put(CTRL + 16'h0007, 8'h02);
        HOST.put_time({48'h9, 32'd100, 8'h00});
        pulse_run(8'h00);
        tchk("modulus", {48'h9, 32'd120, 8'h01});
        HOST.put(CTRL + 16'h0005, 8'h00);
        HOST.put(CTRL + 16'h0001, 8'h01);
        t = {48'hABCD_EF01_2345, 32'h0ABC_DEF0, 8'h00};
        HOST.put_time(t);
        tchk("write_load_off", {48'h9, 32'd120, 8'h01});
        sync_pulse();
        tchk("sync_load", t);
        HOST.put(CTRL + 16'h0009, 8'h00);
        HOST.put(CTRL + 16'h000A, 8'hCC);
        HOST.put(CTRL + 16'h000B, 8'h01);
        HOST.put(time_of_day_pkg::WRITE_BASE, 8'h00);
        HOST.put(CTRL + 16'h0002, 8'h02);
        sync_pulse();
        chk("queue_ready_set", 88'd1, 88'(queue_ready));
        rchk("queue_count", CTRL + 16'h000E, 8'h20);
        for (int i = 0; i < 2; i++) begin
            logic [87:0] q;
            HOST.get_block(CTRL + 16'h000F, q);
            chk("queue_entry", t, q);
        end
        chk("queue_ready_clear", 88'd0, 88'(queue_ready));
        // timer expiry loads; the write to the trigger address pushes the old time
        u = {48'h0000_0000_0042, 32'h0000_1000, 8'h55};
        HOST.put_time(u);
        HOST.put(CTRL + 16'h000C, 8'h05);
        HOST.put(CTRL + 16'h0001, 8'h02);
        HOST.put(CTRL, 8'h04);
        tchk("timer_wait", t);
        tchk("timer_load", u);
        HOST.put(CTRL + 16'h0002, 8'h03);
        gpio_pulse();
        rchk("queue_count_gpio", CTRL + 16'h000E, 8'h20);
        HOST.get_block(CTRL + 16'h000F, v);
        chk("queue_reg_trig", t, v);
        HOST.get_block(CTRL + 16'h000F, v);
        chk("queue_gpio", u, v);
        end_of_test();
    end
endmodule
